// file: hw/sfrs_regs.sv
// Serial buffer, port latches, status word and accumulator of the core
`timescale 1ns/1ps
module sfrs_regs
(
   input  wire logic       clk_i,              // Core clock
   input  wire logic       rst_b_i,            // Synchronous reset, active low
   // Special register access from the core
   input  wire logic [7:0] sfr_addr_i,         // Direct register address
   input  wire logic       sfr_wr_i,           // Write strobe
   input  wire logic       sfr_rd_i,           // Read strobe
   input  wire logic [7:0] sfr_wdata_i,        // Write data
   output logic      [7:0] sfr_rdata_o,        // Read data, one cycle later
   // Arithmetic and bit operations
   input  wire logic       alu_en_i,           // Load ALU result and flags
   input  wire logic       alu_sub_i,          // Subtract instead of add
   input  wire logic       alu_use_carry_i,    // Feed the carry flag in
   input  wire logic [7:0] alu_b_i,            // Second operand
   input  wire logic       bit_carry_we_i,     // Boolean op writes carry
   input  wire logic       bit_carry_i,        // Boolean result
   output logic      [7:0] acc_o,              // Accumulator value
   output logic      [7:0] status_o,           // Status word value
   // Working register addressing
   input  wire logic [2:0] reg_num_i,          // Register number of operand
   output logic      [7:0] reg_addr_o,         // Internal data address
   // Serial engine side
   input  wire logic       rx_load_i,          // Received byte strobe
   input  wire logic [7:0] rx_data_i,          // Received byte
   output logic      [7:0] tx_data_o,          // Transmit buffer
   output logic            tx_load_o,          // Transmit buffer written
   // Upper address pins
   input  wire logic       ext_move_i,         // Indirect external move active
   output logic      [7:0] upper_addr_o,       // Pin levels
   output logic            upper_addr_oe_o,    // Pin drive enable
   // Alternate function port
   input  wire logic       ext_rd_n_i,         // Read strobe from bus unit
   input  wire logic       ext_wr_n_i,         // Write strobe from bus unit
   input  wire logic       txd_i,              // Serial transmit line
   input  wire logic [7:0] alt_pin_i,          // Pin levels in
   output logic      [7:0] alt_pin_o,          // Pin levels out
   output logic      [7:0] alt_pin_oe_o,       // Pin drive enables
   output logic            count_input_one_o,  // Counter 1 input
   output logic            count_input_zero_o, // Counter 0 input
   output logic            ext_irq_one_o,      // External interrupt one
   output logic            ext_irq_zero_o,     // External interrupt zero
   output logic            rxd_o               // Serial receive line
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0] rx_q;             // Receive register
   logic [7:0] tx_q;             // Transmit buffer
   logic       tx_load_q;        // Transmit load pulse
   logic [7:0] upper_q;          // Upper address latch
   logic [7:0] alt_q;            // Alternate function port latch
   logic [7:0] status_q;         // Status word
   logic [7:0] status_d;
   logic [7:0] acc_q;            // Accumulator
   logic [7:0] acc_d;
   logic [7:0] rdata_q;          // Read answer
   logic [7:0] reg_addr_q;       // Working register address
   logic [7:0] up_pin_q;         // Upper address pin levels
   logic       up_oe_q;          // Upper address drive enable
   logic [7:0] alt_meta_q;       // First synchroniser stage
   logic [7:0] alt_sync_q;       // Second synchroniser stage
   logic [7:0] alt_in_q;         // Gated alternate inputs
   logic [7:0] pin_out_q;        // Pin output levels
   logic [7:0] pin_oe_q;         // Pin output enables

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   wire logic hit_serial = sfr_addr_i == sfrs_pkg::ADDR_SERIAL_BUF;
   wire logic hit_upper  = sfr_addr_i == sfrs_pkg::ADDR_UPPER_ADDR;
   wire logic hit_alt    = sfr_addr_i == sfrs_pkg::ADDR_ALT_PORT;
   wire logic hit_sw     = sfr_addr_i == sfrs_pkg::ADDR_STATUS;
   wire logic hit_acc    = sfr_addr_i == sfrs_pkg::ADDR_ARITH;
   wire logic wr_serial  = sfr_wr_i & hit_serial;
   wire logic wr_upper   = sfr_wr_i & hit_upper;
   wire logic wr_alt     = sfr_wr_i & hit_alt;
   wire logic wr_sw      = sfr_wr_i & hit_sw;
   wire logic wr_acc     = sfr_wr_i & hit_acc;

   // Reads of the serial address see the receive side only
   wire logic [7:0] rd_mux =
      hit_serial ? rx_q     :
      hit_upper  ? upper_q  :
      hit_alt    ? alt_q    :
      hit_sw   ? status_q :
      hit_acc  ? acc_q    : sfrs_pkg::RDATA_UNMAPPED;

   // ----------------------------------------------------------------
   // Arithmetic unit
   // ----------------------------------------------------------------
   logic [7:0] alu_res;
   logic       alu_carry;
   logic       alu_half;
   logic       alu_wrap;

   sfrs_alu_flags u_alu
   (
      .a_i      (acc_q),
      .b_i      (alu_b_i),
      .cin_i    (alu_use_carry_i & status_q[sfrs_pkg::SW_CARRY]),
      .sub_i    (alu_sub_i),
      .result_o (alu_res),
      .carry_o  (alu_carry),
      .half_o   (alu_half),
      .wrap_o   (alu_wrap)
   );

   // Hardware result beats a software write landing in the same cycle
   assign acc_d = alu_en_i ? alu_res : (wr_acc ? sfr_wdata_i : acc_q);

   // Software image of the status word before hardware updates
   wire logic [7:0] sw_image = wr_sw ? sfr_wdata_i : status_q;

   // ----------------------------------------------------------------
   // Status word next value
   // ----------------------------------------------------------------
   always_comb
   begin
      status_d = sw_image;
      // Carry: ALU first, then boolean op, then software
      if (alu_en_i)
      begin
         status_d[sfrs_pkg::SW_CARRY] = alu_carry;
         status_d[sfrs_pkg::SW_HALF]  = alu_half;
         status_d[sfrs_pkg::SW_WRAP]  = alu_wrap;
      end
      else if (bit_carry_we_i)
      begin
         status_d[sfrs_pkg::SW_CARRY] = bit_carry_i;
      end
      // Parity follows the accumulator; writes to it are ignored
      status_d[sfrs_pkg::SW_PARITY] = ^acc_d;
   end

   // ----------------------------------------------------------------
   // Alternate function port pins
   // ----------------------------------------------------------------
   // Output functions per bit; input-only bits park at one
   wire logic [7:0] alt_out = {ext_rd_n_i, ext_wr_n_i, 4'hF, txd_i, 1'b1};
   logic [7:0] pin_out_d;
   logic [7:0] pin_oe_d;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_pin
         // Cleared latch bit forces the pin low
         assign pin_out_d[gi] = alt_q[gi] & alt_out[gi];
         // Output bits always drive; input bits drive only to hold zero
         assign pin_oe_d[gi]  = sfrs_pkg::AP_OUT_MASK[gi] | ~alt_q[gi];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Bus registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         rx_q     <= sfrs_pkg::RST_SERIAL_BUF;
         tx_q     <= sfrs_pkg::RST_SERIAL_BUF;
         upper_q  <= sfrs_pkg::RST_UPPER_ADDR;
         alt_q    <= sfrs_pkg::RST_ALT_PORT;
         status_q <= sfrs_pkg::RST_STATUS;
         acc_q    <= sfrs_pkg::RST_ARITH;
      end
      else
      begin
         if (rx_load_i)
            rx_q <= rx_data_i;
         if (wr_serial)
            tx_q <= sfr_wdata_i;
         if (wr_upper)
            upper_q <= sfr_wdata_i;
         if (wr_alt)
            alt_q <= sfr_wdata_i;
         status_q <= status_d;
         acc_q    <= acc_d;
      end
   end

   // ----------------------------------------------------------------
   // Read answer, transmit pulse and bank address
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         rdata_q    <= sfrs_pkg::RDATA_UNMAPPED;
         tx_load_q  <= 1'b0;
         reg_addr_q <= 8'h00;
      end
      else
      begin
         // Read data holds until the next read
         if (sfr_rd_i)
            rdata_q <= rd_mux;
         tx_load_q  <= wr_serial;
         // Bank field picks the block of eight bytes
         reg_addr_q <= {3'h0, status_q[sfrs_pkg::SW_BANK_HI:sfrs_pkg::SW_BANK_LO],
                        reg_num_i};
      end
   end

   // ----------------------------------------------------------------
   // Pin side registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         up_pin_q  <= sfrs_pkg::RST_UPPER_ADDR;
         up_oe_q   <= 1'b0;
         alt_meta_q <= 8'h00;
         alt_sync_q <= 8'h00;
         alt_in_q   <= 8'h00;
         pin_out_q  <= sfrs_pkg::RST_ALT_PORT;
         pin_oe_q   <= sfrs_pkg::AP_OUT_MASK;
      end
      else
      begin
         // Latch reaches the pins only during external moves
         up_pin_q   <= upper_q;
         up_oe_q    <= ext_move_i;
         alt_meta_q <= alt_pin_i;
         alt_sync_q <= alt_meta_q;
         // Input functions see zero while their latch bit is clear
         alt_in_q   <= alt_sync_q & alt_q;
         pin_out_q  <= pin_out_d;
         pin_oe_q   <= pin_oe_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign sfr_rdata_o        = rdata_q;
   assign acc_o              = acc_q;
   assign status_o           = status_q;
   assign reg_addr_o         = reg_addr_q;
   assign tx_data_o          = tx_q;
   assign tx_load_o          = tx_load_q;
   assign upper_addr_o       = up_pin_q;
   assign upper_addr_oe_o    = up_oe_q;
   assign alt_pin_o          = pin_out_q;
   assign alt_pin_oe_o       = pin_oe_q;
   // Input functions taken off the gated pins
   assign count_input_one_o  = alt_in_q[sfrs_pkg::AP_CNT1];
   assign count_input_zero_o = alt_in_q[sfrs_pkg::AP_CNT0];
   assign ext_irq_one_o      = alt_in_q[sfrs_pkg::AP_IRQ1];
   assign ext_irq_zero_o     = alt_in_q[sfrs_pkg::AP_IRQ0];
   assign rxd_o              = alt_in_q[sfrs_pkg::AP_RXD];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   // Write to the serial address lands on the transmit side only
   sequence s_serial_write;
      wr_serial && !rx_load_i;
   endsequence
   sequence s_serial_split;
      tx_data_o == $past(sfr_wdata_i) && rx_q == $past(rx_q) && tx_load_o;
   endsequence

   chk_serial_split: assert property (s_serial_write |=> s_serial_split)
      else $error("serial buffer write did not go to transmit side");
   chk_serial_read: assert property
      (sfr_rd_i && hit_serial |=> sfr_rdata_o == $past(rx_q))
      else $error("serial buffer read did not return receive side");
   chk_upper_drive: assert property
      (ext_move_i |=> upper_addr_oe_o && upper_addr_o == $past(upper_q))
      else $error("upper address not driven during external move");
   chk_upper_idle: assert property (!ext_move_i |=> !upper_addr_oe_o)
      else $error("upper address driven outside external move");
   chk_port_stuck: assert property
      (1'b1 |=> (alt_pin_o & ~$past(alt_q)) == 8'h00
                && (alt_pin_oe_o | $past(alt_q)) == 8'hFF)
      else $error("cleared port bit not held at zero");
   chk_port_strobes: assert property
      (alt_q[sfrs_pkg::AP_RD_N] |=> alt_pin_o[sfrs_pkg::AP_RD_N] == $past(ext_rd_n_i))
      else $error("read strobe not passed to port pin");
   chk_carry_alu: assert property
      (alu_en_i |=> status_q[sfrs_pkg::SW_CARRY] == $past(alu_carry)
                 && status_q[sfrs_pkg::SW_WRAP] == $past(alu_wrap))
      else $error("carry or overflow not taken from arithmetic unit");
   chk_user_flags: assert property
      (!wr_sw |=> $stable(status_q[sfrs_pkg::SW_USER0])
               && $stable(status_q[sfrs_pkg::SW_USER1]))
      else $error("user flag changed without software write");
   chk_parity_flag: assert property
      (status_q[sfrs_pkg::SW_PARITY] == ^acc_q)
      else $error("parity flag does not match accumulator");
   chk_bank_addr: assert property
      (1'b1 |=> reg_addr_o == {3'h0,
         $past(status_q[sfrs_pkg::SW_BANK_HI:sfrs_pkg::SW_BANK_LO]), $past(reg_num_i)})
      else $error("working register address wrong");
   chk_reset_vals: assert property
      (@(posedge clk_i) disable iff (1'b0) !rst_b_i |=>
         status_q == sfrs_pkg::RST_STATUS && acc_q == sfrs_pkg::RST_ARITH
         && upper_q == sfrs_pkg::RST_UPPER_ADDR && alt_q == sfrs_pkg::RST_ALT_PORT
         && tx_q == sfrs_pkg::RST_SERIAL_BUF)
      else $error("register reset value wrong");

endmodule : sfrs_regs

// file: hw/sfrs_pkg.sv
// Package of offsets, reset values and bit positions for the core status registers
package sfrs_pkg;

   // ----------------------------------------------------------------
   // Special register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_SERIAL_BUF = 8'h99;  // Serial data buffer
   localparam logic [7:0] ADDR_UPPER_ADDR = 8'hA0;  // Upper address latch
   localparam logic [7:0] ADDR_ALT_PORT   = 8'hB0;  // Alternate function port
   localparam logic [7:0] ADDR_STATUS     = 8'hD0;  // Status word
   localparam logic [7:0] ADDR_ARITH      = 8'hE0;  // Accumulator

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_SERIAL_BUF  = 8'h00;
   localparam logic [7:0] RST_UPPER_ADDR  = 8'hFF;
   localparam logic [7:0] RST_ALT_PORT    = 8'hFF;
   localparam logic [7:0] RST_STATUS      = 8'h00;
   localparam logic [7:0] RST_ARITH       = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED  = 8'h00;  // Answer for unmapped reads

   // ----------------------------------------------------------------
   // Status word bit positions
   // ----------------------------------------------------------------
   localparam int SW_CARRY   = 7;
   localparam int SW_HALF    = 6;
   localparam int SW_USER0   = 5;
   localparam int SW_BANK_HI = 4;
   localparam int SW_BANK_LO = 3;
   localparam int SW_WRAP    = 2;
   localparam int SW_USER1   = 1;
   localparam int SW_PARITY  = 0;

   // ----------------------------------------------------------------
   // Alternate function port bit positions
   // ----------------------------------------------------------------
   localparam int AP_RD_N    = 7;   // External read strobe out
   localparam int AP_WR_N    = 6;   // External write strobe out
   localparam int AP_CNT1    = 5;   // Counter 1 count input
   localparam int AP_CNT0    = 4;   // Counter 0 count input
   localparam int AP_IRQ1    = 3;   // External interrupt one
   localparam int AP_IRQ0    = 2;   // External interrupt zero
   localparam int AP_TXD     = 1;   // Serial transmit out
   localparam int AP_RXD     = 0;   // Serial receive in
   // Bits whose alternate function is an output
   localparam logic [7:0] AP_OUT_MASK = 8'hC2;

   // ----------------------------------------------------------------
   // Working register bank addressing
   // ----------------------------------------------------------------
   localparam int BANK_W   = 2;
   localparam int REGNUM_W = 3;

endpackage : sfrs_pkg

// file: hw/sfrs_alu_flags.sv
// Arithmetic unit producing the result and carry, half carry, overflow flags
`timescale 1ns/1ps
module sfrs_alu_flags
(
   input  wire logic [7:0] a_i,        // Accumulator operand
   input  wire logic [7:0] b_i,        // Second operand
   input  wire logic       cin_i,      // Carry or borrow in
   input  wire logic       sub_i,      // High for subtraction
   output logic      [7:0] result_o,   // Sum or difference
   output logic            carry_o,    // Carry or borrow out of bit 7
   output logic            half_o,     // Carry or borrow at the nibble boundary
   output logic            wrap_o      // Signed overflow
);

   // ----------------------------------------------------------------
   // Three widths of the same operation give the three carries
   // ----------------------------------------------------------------
   wire logic [8:0] full_add = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
   wire logic [8:0] full_sub = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
   wire logic [4:0] nib_add  = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
   wire logic [4:0] nib_sub  = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin_i};
   wire logic [7:0] low_add  = {1'b0, a_i[6:0]} + {1'b0, b_i[6:0]} + {7'h00, cin_i};
   wire logic [7:0] low_sub  = {1'b0, a_i[6:0]} - {1'b0, b_i[6:0]} - {7'h00, cin_i};

   // Carry into bit 7, i.e. out of bit 6
   wire logic       c6 = sub_i ? low_sub[7] : low_add[7];

   // Borrow shows as the top bit wrapping, same as a carry for adds
   assign result_o = sub_i ? full_sub[7:0] : full_add[7:0];
   assign carry_o  = sub_i ? full_sub[8]   : full_add[8];
   assign half_o   = sub_i ? nib_sub[4]    : nib_add[4];
   // Overflow when exactly one of the two top carries occurs
   assign wrap_o   = c6 ^ carry_o;

endmodule : sfrs_alu_flags

// file: test/sfrs_pad_model.sv
// Pad model of the alternate function port pins as seen from the board
`timescale 1ns/1ps
module sfrs_pad_model
(
   input  wire logic [7:0] dev_lvl_i,  // Levels the device drives
   input  wire logic [7:0] dev_oe_i,   // Device drive enables
   input  wire logic [7:0] brd_lvl_i,  // Levels the board drives
   output logic      [7:0] pin_lvl_o   // Resolved pin levels
);
   // ----------------------------------------------------------------
   // Pin resolution
   // ----------------------------------------------------------------
   // Device wins where it drives; the board only shows on released pins
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         pin_lvl_o[i] = dev_oe_i[i] ? dev_lvl_i[i] : brd_lvl_i[i];
   end
endmodule : sfrs_pad_model

// file: test/sfrs_regs_tb.sv
// Self-checking testbench of the core status registers
`timescale 1ns/1ps
module sfrs_regs_tb;
   logic       clk, rst_b, wr, rd, alu_en, sub, uc, bcw, bc, rxl, mv, rdn, wrn, txd;
   logic [7:0] addr, wd, rdat, b, acc, sw, ra, rxd8, txb, ua, po, poe, pi, brd;
   logic [2:0] num;
   logic       txl, uoe, c1, c0, i1, i0, rx;
   int         error_cnt, comparisons;
   sfrs_regs u_sfrs_regs (.clk_i(clk), .rst_b_i(rst_b), .sfr_addr_i(addr), .sfr_wr_i(wr),
      .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdat), .alu_en_i(alu_en), .alu_sub_i(sub),
      .alu_use_carry_i(uc), .alu_b_i(b), .bit_carry_we_i(bcw), .bit_carry_i(bc), .acc_o(acc),
      .status_o(sw), .reg_num_i(num), .reg_addr_o(ra), .rx_load_i(rxl), .rx_data_i(rxd8),
      .tx_data_o(txb), .tx_load_o(txl), .ext_move_i(mv), .upper_addr_o(ua),
      .upper_addr_oe_o(uoe), .ext_rd_n_i(rdn), .ext_wr_n_i(wrn), .txd_i(txd), .alt_pin_i(pi),
      .alt_pin_o(po), .alt_pin_oe_o(poe), .count_input_one_o(c1), .count_input_zero_o(c0),
      .ext_irq_one_o(i1), .ext_irq_zero_o(i0), .rxd_o(rx));
   sfrs_pad_model u_sfrs_pad_model (.dev_lvl_i(po), .dev_oe_i(poe), .brd_lvl_i(brd),
      .pin_lvl_o(pi));
   // ----------------------------------------------------------------
   // Clock, checking and closing
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task end_of_test;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   // Register write: strobe for one edge
   task wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) addr <= a; wd <= d; wr <= 1'b1;
      @(posedge clk) wr <= 1'b0;
   endtask : wreg
   // Register read: data settles after the taking edge
   task rreg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk) addr <= a; rd <= 1'b1;
      @(posedge clk) rd <= 1'b0;
      #1 chk(rdat, exp);
   endtask : rreg
   // One ALU operation, then the new status word
   task alu(input logic [7:0] bv, input logic s, input logic u, input logic [7:0] ea,
            input logic [7:0] es);
      @(posedge clk) b <= bv; sub <= s; uc <= u; alu_en <= 1'b1;
      @(posedge clk) alu_en <= 1'b0;
      #1 chk(acc, ea);
      chk(sw, es);
   endtask : alu
   // Watchdog far beyond the ninety or so cycles the tests need
   initial
   begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end
   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      {rst_b, wr, rd, alu_en, sub, uc, bcw, bc, rxl, mv, txd} = '0;
      {rdn, wrn} = 2'b11;
      {addr, wd, b, rxd8, num} = '0;
      brd = 8'h00;
      error_cnt = 0;
      comparisons = 0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      // Reset values, then an unmapped place
      rreg(sfrs_pkg::ADDR_SERIAL_BUF, 8'h00);
      rreg(sfrs_pkg::ADDR_UPPER_ADDR, 8'hff);
      rreg(sfrs_pkg::ADDR_ALT_PORT, 8'hff);
      rreg(sfrs_pkg::ADDR_STATUS, 8'h00);
      rreg(sfrs_pkg::ADDR_ARITH, 8'h00);
      rreg(8'h98, sfrs_pkg::RDATA_UNMAPPED);
      // Split serial buffer: receive side read, transmit side written
      @(posedge clk) rxl <= 1'b1; rxd8 <= 8'ha5;
      @(posedge clk) rxl <= 1'b0;
      wreg(sfrs_pkg::ADDR_SERIAL_BUF, 8'h5a);
      #1 chk(txb, 8'h5a);
      chk({7'h00, txl}, 8'h01);
      rreg(sfrs_pkg::ADDR_SERIAL_BUF, 8'ha5);
      // Upper address reaches the pins only during external moves
      wreg(sfrs_pkg::ADDR_UPPER_ADDR, 8'h3c);
      rreg(sfrs_pkg::ADDR_UPPER_ADDR, 8'h3c);
      chk({7'h00, uoe}, 8'h00);
      @(posedge clk) mv <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk({7'h00, uoe}, 8'h01);
      chk(ua, 8'h3c);
      mv <= 1'b0;
      // Alternate inputs follow the pins, outputs carry the strobes
      brd = 8'h14;
      rdn <= 1'b0;
      repeat (5) @(posedge clk);
      #1 chk({3'h0, c1, c0, i1, i0, rx}, 8'h0a);
      chk(po & 8'hc2, 8'h40);
      brd = 8'h29;
      rdn <= 1'b1; wrn <= 1'b0; txd <= 1'b1;
      repeat (5) @(posedge clk);
      #1 chk({3'h0, c1, c0, i1, i0, rx}, 8'h15);
      chk(po & 8'hc2, 8'h82);
      // Cleared latch bits stick the pins at zero
      brd = 8'hff;
      wreg(sfrs_pkg::ADDR_ALT_PORT, 8'h7b);
      repeat (4) @(posedge clk);
      #1 chk(po & 8'h84, 8'h00);
      chk({7'h00, i0}, 8'h00);
      chk(poe, 8'hc6);
      rreg(sfrs_pkg::ADDR_ALT_PORT, 8'h7b);
      // Flags from the arithmetic unit, carry as boolean accumulator
      wreg(sfrs_pkg::ADDR_ARITH, 8'h7f);
      alu(8'h01, 1'b0, 1'b0, 8'h80, 8'h45);
      alu(8'h81, 1'b0, 1'b0, 8'h01, 8'h85);
      alu(8'h00, 1'b1, 1'b1, 8'h00, 8'h00);
      @(posedge clk) bcw <= 1'b1; bc <= 1'b1;
      @(posedge clk) bcw <= 1'b0;
      #1 chk(sw, 8'h80);
      // Bank select forms the working register address
      for (int k = 0; k < 4; k++)
      begin
         num <= 3'(7 - k);
         wreg(sfrs_pkg::ADDR_STATUS, 8'(k << 3));
         @(posedge clk) #1 chk(ra, 8'(k * 8 + 7 - k));
      end
      // User flags and bank survive arithmetic; parity bit is not writable
      wreg(sfrs_pkg::ADDR_STATUS, 8'h3b);
      rreg(sfrs_pkg::ADDR_STATUS, 8'h3a);
      alu(8'h0f, 1'b0, 1'b0, 8'h0f, 8'h3a);
      alu(8'hf8, 1'b0, 1'b0, 8'h07, 8'hfb);
      end_of_test();
   end
endmodule : sfrs_regs_tb
